// ==== logic/scpa_pkg.sv ====
// Shared constants for the strap capture and pin alternate function block.
// Assumes a 32-bit classic Wishbone slave with byte addresses on an 8-bit address bus.
package scpa_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int ADDR_W       = 8;     // Byte address width
    localparam int DATA_W       = 32;    // Bus data width
    localparam int SEL_W        = 4;     // Byte enables
    localparam int NUM_LED      = 5;     // LED pins 0..4
    localparam int NUM_GPIO     = 7;     // GPIO 0..6
    localparam int STRAP_ADDR_W = 3;     // Strapped address bits
    localparam int MGMT_ADDR_W  = 5;     // Address field of a management frame
    localparam int ROUTE_A_W    = 4;     // Wake routing onto GPIO 0..3
    localparam int ROUTE_B_W    = 3;     // Wake routing onto GPIO 4..6
    localparam int VB_W         = 16;    // Vendor bank entry width
    localparam int VB_FIRST     = 'h13;  // First jack-dependent entry
    localparam int VB_LAST      = 'h1e;  // Last jack-dependent entry
    localparam int VB_COUNT     = VB_LAST - VB_FIRST + 1;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_STRAP_STAT = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CTRL       = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_LED_POL    = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_GPIO_EN    = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_GPIO_DIR   = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_GPIO_OUT   = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_GPIO_IN    = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_ROUTE_A    = 8'h1c;
    localparam logic [ADDR_W-1:0] OFS_ROUTE_B    = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_VB_BASE    = 8'h40;
    localparam logic [ADDR_W-1:0] OFS_VB_END     = 8'h70;  // First byte past the bank
    localparam int                WORD_SHIFT     = 2;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int ST_ADDR_LSB  = 0;   // Strapped address [2:0]
    localparam int ST_POL_LSB   = 4;   // LED polarity [8:4]
    localparam int ST_STYLE_BIT = 9;   // 1 = individual LEDs
    localparam int ST_CLKEN_BIT = 10;  // Clock-out strap
    localparam int ST_JACK_BIT  = 11;  // Jack compatibility strap
    localparam int ST_BCAST_BIT = 12;  // Raw broadcast strap level
    localparam int CTRL_BCAST_BIT  = 0;   // Broadcast address enable
    localparam int CTRL_CLKSRC_BIT = 1;   // Clock-out source select
    localparam int GPIO_INT_PIN = 5;   // Interrupt pin as GPIO
    localparam int GPIO_CLK_PIN = 6;   // Clock-out pin as GPIO

    // ------------------------------------------------------------
    // Values
    // ------------------------------------------------------------
    localparam logic                   CLKSRC_INTERNAL = 1'h0;
    localparam logic [MGMT_ADDR_W-1:0] MGMT_BROADCAST  = 5'h00;
    localparam logic [VB_W-1:0]        VB_STD_BASE     = 16'h0100;  // Plain default
    localparam logic [VB_W-1:0]        VB_JACK_XOR     = 16'h8000;  // Flipped into the default when the jack strap is high

    typedef enum logic {ST_LOAD, ST_RUN} scpa_state_e;

    // Reset value of one vendor bank entry for the given jack strap level
    function automatic logic [VB_W-1:0] scpa_vb_default(input int idx, input logic jack);
        logic [VB_W-1:0] v;
        v = VB_STD_BASE | VB_W'(idx);
        return jack ? (v ^ VB_JACK_XOR) : v;
    endfunction

    // Merge the two low byte lanes of a bus write into a 16-bit field
    function automatic logic [VB_W-1:0] scpa_merge(input logic [VB_W-1:0] old_v,
                                                   input logic [DATA_W-1:0] wdat,
                                                   input logic [SEL_W-1:0] sel);
        logic [VB_W-1:0] v;
        v = old_v;
        if (sel[0]) v[7:0] = wdat[7:0];
        if (sel[1]) v[15:8] = wdat[15:8];
        return v;
    endfunction

endpackage

// ==== logic/scpa_pin_mux.sv ====
// Per-pin selection between primary function and general purpose I/O.
// Assumes the caller supplies primary and GPIO drive already decided per pin.
`timescale 1ns/100ps
module scpa_pin_mux #(
    parameter int N = 7
) (
    input  wire logic         clock_in,
    input  wire logic         rst_in,
    input  wire logic         released_in,   // Straps taken, pins may drive
    input  wire logic [N-1:0] gpio_en_in,    // 1 = pin is GPIO
    input  wire logic [N-1:0] prim_out_in,   // Primary function level
    input  wire logic [N-1:0] prim_oe_in,    // Primary function enable
    input  wire logic [N-1:0] gpio_out_in,   // GPIO level
    input  wire logic [N-1:0] gpio_oe_in,    // GPIO enable
    output logic      [N-1:0] pin_out,
    output logic      [N-1:0] pin_oe_out
);

    // ------------------------------------------------------------
    // One registered selector per pin
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_pin
            wire logic sel_out;  // Chosen level
            wire logic sel_oe;   // Chosen enable

            // GPIO enable overrides the primary function
            assign sel_out = gpio_en_in[g] ? gpio_out_in[g] : prim_out_in[g];
            // Nothing drives while straps may still be sampled
            assign sel_oe  = released_in & (gpio_en_in[g] ? gpio_oe_in[g] : prim_oe_in[g]);

            // Registered so pins change only on clock edges
            always_ff @(posedge clock_in or posedge rst_in) begin
                if (rst_in) begin
                    pin_out[g]    <= 1'h0;
                    pin_oe_out[g] <= 1'h0;
                end else begin
                    pin_out[g]    <= sel_out;
                    pin_oe_out[g] <= sel_oe;
                end
            end
        end
    endgenerate

endmodule

// ==== logic/scpa_strap_top.sv ====
// Strap capture, management address match and shared pin control.
// Assumes a classic Wishbone master and board straps settled at reset release.
`timescale 1ns/100ps
module scpa_strap_top
    import scpa_pkg::*;
(
    input  wire logic                              clock_in,
    input  wire logic                              rst_in,
    // Wishbone slave
    input  wire logic                              wb_cyc_in,
    input  wire logic                              wb_stb_in,
    input  wire logic                              wb_we_in,
    input  wire logic [scpa_pkg::ADDR_W-1:0]       wb_adr_in,
    input  wire logic [scpa_pkg::SEL_W-1:0]        wb_sel_in,
    input  wire logic [scpa_pkg::DATA_W-1:0]       wb_dat_in,
    output logic      [scpa_pkg::DATA_W-1:0]       wb_dat_out,
    output logic                                   wb_ack_out,
    // Straps
    input  wire logic [scpa_pkg::STRAP_ADDR_W-1:0] mgmt_addr_straps_in,
    input  wire logic                              broadcast_addr_strap_in,
    input  wire logic                              refclk_out_enable_strap_in,
    input  wire logic                              led_style_strap_in,
    input  wire logic                              jack_center_tap_compat_strap_in,
    // Shared pins: 0..4 LEDs, 5 interrupt, 6 clock-out
    input  wire logic [scpa_pkg::NUM_GPIO-1:0]     pin_in,
    output logic      [scpa_pkg::NUM_GPIO-1:0]     pin_out,
    output logic      [scpa_pkg::NUM_GPIO-1:0]     pin_oe_out,
    // Primary functions from the rest of the device
    input  wire logic [scpa_pkg::NUM_LED-1:0]      led_lit_in,
    input  wire logic                              int_req_in,
    input  wire logic                              int_refclk_in,
    input  wire logic                              alt_refclk_in,
    input  wire logic                              wake_event_in,
    // Management frame address check
    input  wire logic [scpa_pkg::MGMT_ADDR_W-1:0]  frame_addr_in,
    input  wire logic                              frame_addr_valid_in,
    output logic                                   frame_addr_match_out,
    // Configuration seen by the rest of the device
    output logic [scpa_pkg::STRAP_ADDR_W-1:0]      mgmt_addr_out,
    output logic                                   broadcast_addr_enable_out,
    output logic                                   led_style_out,
    output logic                                   strap_done_out
);
    import scpa_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    scpa_state_e                 state_ff;          // Load then run
    scpa_state_e                 nxt_state;
    logic [STRAP_ADDR_W-1:0]     addr_strap_ff;     // Captured address
    logic                        bcast_strap_ff;    // Raw broadcast strap
    logic                        clken_strap_ff;    // Clock-out strap
    logic                        style_ff;          // LED style strap
    logic                        jack_ff;           // Jack strap
    logic                        bcast_en_ff;       // Broadcast enable bit
    logic                        clksrc_ff;         // Clock-out source
    logic [NUM_LED-1:0]          led_pol_ff;        // 1 = LED active high
    logic [NUM_GPIO-1:0]         gpio_en_ff;        // Pin is GPIO
    logic [NUM_GPIO-1:0]         gpio_dir_ff;       // GPIO drives
    logic [NUM_GPIO-1:0]         gpio_dout_ff;      // GPIO level
    logic [NUM_GPIO-1:0]         gpio_in_ff;        // Sampled pin levels
    logic [ROUTE_A_W-1:0]        route_a_ff;        // Wake onto GPIO 0..3
    logic [ROUTE_B_W-1:0]        route_b_ff;        // Wake onto GPIO 4..6
    logic [VB_W-1:0]             vb_ff [VB_COUNT];  // Vendor bank entries
    logic                        ack_ff;
    logic [DATA_W-1:0]           rdat_ff;
    logic                        match_ff;

    // ------------------------------------------------------------
    // Sequencing and bus decode
    // ------------------------------------------------------------
    wire logic              loading  = (state_ff == ST_LOAD);
    wire logic              running  = (state_ff == ST_RUN);
    // Requests wait for the strap load so it never races a write
    wire logic              req      = wb_cyc_in & wb_stb_in & ~ack_ff & running;
    wire logic              wr       = req & wb_we_in;
    wire logic              hit_stat = (wb_adr_in == OFS_STRAP_STAT);
    wire logic              hit_ctrl = (wb_adr_in == OFS_CTRL);
    wire logic              hit_pol  = (wb_adr_in == OFS_LED_POL);
    wire logic              hit_en   = (wb_adr_in == OFS_GPIO_EN);
    wire logic              hit_dir  = (wb_adr_in == OFS_GPIO_DIR);
    wire logic              hit_dout = (wb_adr_in == OFS_GPIO_OUT);
    wire logic              hit_gin  = (wb_adr_in == OFS_GPIO_IN);
    wire logic              hit_ra   = (wb_adr_in == OFS_ROUTE_A);
    wire logic              hit_rb   = (wb_adr_in == OFS_ROUTE_B);
    wire logic              hit_vb   = (wb_adr_in >= OFS_VB_BASE) & (wb_adr_in < OFS_VB_END)
                                       & (wb_adr_in[WORD_SHIFT-1:0] == '0);
    wire logic [ADDR_W-1:0] vb_off   = wb_adr_in - OFS_VB_BASE;
    wire logic [ADDR_W-1:0] vb_idx   = vb_off >> WORD_SHIFT;
    wire logic              lane0    = wb_sel_in[0];

    // Strap status word
    wire logic [DATA_W-1:0] stat_word = (DATA_W'(addr_strap_ff) << ST_ADDR_LSB)
                                      | (DATA_W'(led_pol_ff) << ST_POL_LSB)
                                      | (DATA_W'(style_ff) << ST_STYLE_BIT)
                                      | (DATA_W'(clken_strap_ff) << ST_CLKEN_BIT)
                                      | (DATA_W'(jack_ff) << ST_JACK_BIT)
                                      | (DATA_W'(bcast_strap_ff) << ST_BCAST_BIT);
    wire logic [DATA_W-1:0] ctrl_word = (DATA_W'(bcast_en_ff) << CTRL_BCAST_BIT)
                                      | (DATA_W'(clksrc_ff) << CTRL_CLKSRC_BIT);
    // Unmapped addresses read as zero and are still acknowledged
    wire logic [DATA_W-1:0] rd_data   = hit_stat ? stat_word :
                                        hit_ctrl ? ctrl_word :
                                        hit_pol  ? DATA_W'(led_pol_ff) :
                                        hit_en   ? DATA_W'(gpio_en_ff) :
                                        hit_dir  ? DATA_W'(gpio_dir_ff) :
                                        hit_dout ? DATA_W'(gpio_dout_ff) :
                                        hit_gin  ? DATA_W'(gpio_in_ff) :
                                        hit_ra   ? DATA_W'(route_a_ff) :
                                        hit_rb   ? DATA_W'(route_b_ff) :
                                        hit_vb   ? DATA_W'(vb_ff[vb_idx[3:0]]) : '0;

    // ------------------------------------------------------------
    // Load then run: one strap sample after reset release
    // ------------------------------------------------------------
    assign nxt_state = ST_RUN;

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            state_ff <= ST_LOAD;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Captured straps; async reset cannot take a port value, so load is clocked
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            addr_strap_ff  <= '0;
            bcast_strap_ff <= 1'h0;
            clken_strap_ff <= 1'h0;
            style_ff       <= 1'h0;
            jack_ff        <= 1'h0;
        end else if (loading) begin
            addr_strap_ff  <= mgmt_addr_straps_in;
            bcast_strap_ff <= broadcast_addr_strap_in;
            clken_strap_ff <= refclk_out_enable_strap_in;
            style_ff       <= led_style_strap_in;
            jack_ff        <= jack_center_tap_compat_strap_in;
        end
    end

    // ------------------------------------------------------------
    // Software registers; broadcast enable, LED polarity and vendor bank defaults come from straps
    // ------------------------------------------------------------
    // Control bits: broadcast enable and clock-out source
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            bcast_en_ff <= 1'h0;
            clksrc_ff   <= CLKSRC_INTERNAL;
        end else if (loading) begin
            bcast_en_ff <= ~broadcast_addr_strap_in;
            clksrc_ff   <= CLKSRC_INTERNAL;
        end else if (wr & hit_ctrl & lane0) begin
            bcast_en_ff <= wb_dat_in[CTRL_BCAST_BIT];
            clksrc_ff   <= wb_dat_in[CTRL_CLKSRC_BIT];
        end
    end

    // LED polarity: default is the inverse of the level on each LED pin
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            led_pol_ff <= '0;
        end else if (loading) begin
            led_pol_ff <= ~pin_in[NUM_LED-1:0];
        end else if (wr & hit_pol & lane0) begin
            led_pol_ff <= wb_dat_in[NUM_LED-1:0];
        end
    end

    // GPIO enable, direction, data and wake routing
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            gpio_en_ff   <= '0;
            gpio_dir_ff  <= '0;
            gpio_dout_ff <= '0;
            route_a_ff   <= '0;
            route_b_ff   <= '0;
        end else if (wr & lane0) begin
            if (hit_en) gpio_en_ff <= wb_dat_in[NUM_GPIO-1:0];
            if (hit_dir) gpio_dir_ff <= wb_dat_in[NUM_GPIO-1:0];
            if (hit_dout) gpio_dout_ff <= wb_dat_in[NUM_GPIO-1:0];
            if (hit_ra) route_a_ff <= wb_dat_in[ROUTE_A_W-1:0];
            if (hit_rb) route_b_ff <= wb_dat_in[ROUTE_B_W-1:0];
        end
    end

    // Pin levels for the GPIO input register, every cycle
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            gpio_in_ff <= '0;
        end else begin
            gpio_in_ff <= pin_in;
        end
    end

    // Vendor bank: defaults depend on the jack strap, then software owns them
    genvar v;
    generate
        for (v = 0; v < VB_COUNT; v++) begin : g_vb
            wire logic hit_me = wr & hit_vb & (vb_idx == ADDR_W'(v));
            always_ff @(posedge clock_in or posedge rst_in) begin
                if (rst_in) begin
                    vb_ff[v] <= '0;
                end else if (loading) begin
                    vb_ff[v] <= scpa_vb_default(VB_FIRST + v, jack_center_tap_compat_strap_in);
                end else if (hit_me) begin
                    vb_ff[v] <= scpa_merge(vb_ff[v], wb_dat_in, wb_sel_in);
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Bus answer: ack one cycle after the request is taken
    // ------------------------------------------------------------
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            ack_ff  <= 1'h0;
            rdat_ff <= '0;
        end else begin
            ack_ff  <= req;
            rdat_ff <= (req & ~wb_we_in) ? rd_data : '0;
        end
    end

    // ------------------------------------------------------------
    // Management address match
    // ------------------------------------------------------------
    wire logic own_hit   = (frame_addr_in == MGMT_ADDR_W'(addr_strap_ff));
    wire logic bcast_hit = bcast_en_ff & (frame_addr_in == MGMT_BROADCAST);

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            match_ff <= 1'h0;
        end else begin
            match_ff <= running & frame_addr_valid_in & (own_hit | bcast_hit);
        end
    end

    // ------------------------------------------------------------
    // Primary and GPIO drive per pin
    // ------------------------------------------------------------
    logic [NUM_GPIO-1:0] prim_out;
    logic [NUM_GPIO-1:0] prim_oe;
    logic [NUM_GPIO-1:0] route_all;
    logic [NUM_GPIO-1:0] wake_on;
    logic [NUM_GPIO-1:0] gp_out;
    logic [NUM_GPIO-1:0] gp_oe;

    // LEDs: pin level is the lit state seen through the polarity bit
    assign prim_out[NUM_LED-1:0]   = ~(led_lit_in ^ led_pol_ff);
    assign prim_oe[NUM_LED-1:0]    = '1;
    // Interrupt is open-drain, active low
    assign prim_out[GPIO_INT_PIN]  = 1'h0;
    assign prim_oe[GPIO_INT_PIN]   = int_req_in;
    // Clock-out only drives when its strap was high
    assign prim_out[GPIO_CLK_PIN]  = clksrc_ff ? alt_refclk_in : int_refclk_in;
    assign prim_oe[GPIO_CLK_PIN]   = clken_strap_ff;
    // Wake is active low and only reaches pins that are GPIO
    assign route_all = {route_b_ff, route_a_ff};
    assign wake_on   = route_all & gpio_en_ff;
    assign gp_out    = (wake_on & {NUM_GPIO{~wake_event_in}}) | (~wake_on & gpio_dout_ff);
    assign gp_oe     = wake_on | gpio_dir_ff;

    scpa_pin_mux #(
        .N (NUM_GPIO)
    ) u_mux (
        .clock_in    (clock_in),
        .rst_in      (rst_in),
        .released_in (running),
        .gpio_en_in  (gpio_en_ff),
        .prim_out_in (prim_out),
        .prim_oe_in  (prim_oe),
        .gpio_out_in (gp_out),
        .gpio_oe_in  (gp_oe),
        .pin_out     (pin_out),
        .pin_oe_out  (pin_oe_out)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign wb_ack_out                = ack_ff;
    assign wb_dat_out                = rdat_ff;
    assign frame_addr_match_out      = match_ff;
    assign mgmt_addr_out             = addr_strap_ff;
    assign broadcast_addr_enable_out = bcast_en_ff;
    assign led_style_out             = style_ff;
    assign strap_done_out            = running;

endmodule

// ==== tb/scpa_board_model.sv ====
// Board side model: strap pulls and LEDs on the shared pins.
// Assumes pin_out/pin_oe_out of the block; resolves each pin level.
`timescale 1ns/100ps
module scpa_board_model (
    input  wire logic [6:0] pin_out,    // Device drive level
    input  wire logic [6:0] pin_oe,     // Device drive enable
    input  wire logic [6:0] pull_in,    // Strap resistor level per pin
    output logic      [6:0] pin_in      // Resolved pin level
);
    // Released pins fall back to their strap pull, never the last driven level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & pull_in);
endmodule

// ==== tb/scpa_strap_top_props.sv ====
// Checker for strap capture, address match and bus answer timing.
// Assumes it is bound onto scpa_strap_top and sees only its ports.
`timescale 1ns/100ps
module scpa_strap_top_props (
    input wire logic clock_in, rst_in, wb_cyc_in, wb_stb_in, wb_ack_out,
    input wire logic [2:0] mgmt_addr_straps_in, mgmt_addr_out,
    input wire logic broadcast_addr_strap_in, led_style_strap_in,
    input wire logic [4:0] frame_addr_in,
    input wire logic frame_addr_valid_in, frame_addr_match_out,
    input wire logic broadcast_addr_enable_out, led_style_out, strap_done_out,
    input wire logic [6:0] pin_oe_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    wire own_hit = frame_addr_in == {2'h0, mgmt_addr_out};
    wire zero_hit = broadcast_addr_enable_out && frame_addr_in == 5'h00;
    own_match_a: assert property (frame_addr_valid_in && strap_done_out && own_hit |=> frame_addr_match_out)
        else $error("own address not matched");
    bcast_match_a: assert property (frame_addr_valid_in && strap_done_out && zero_hit |=> frame_addr_match_out)
        else $error("address zero not matched");
    no_match_a: assert property (!(frame_addr_valid_in && (own_hit || zero_hit)) |=> !frame_addr_match_out)
        else $error("match without cause");
    bcast_load_a: assert property ($rose(strap_done_out) |-> broadcast_addr_enable_out == !$past(broadcast_addr_strap_in))
        else $error("broadcast enable not inverse of strap");
    addr_load_a: assert property ($rose(strap_done_out) |-> mgmt_addr_out == $past(mgmt_addr_straps_in))
        else $error("address strap not captured");
    style_load_a: assert property ($rose(strap_done_out) |-> led_style_out == $past(led_style_strap_in))
        else $error("LED style strap not captured");
    addr_hold_a: assert property (strap_done_out |=> strap_done_out && $stable(mgmt_addr_out))
        else $error("straps taken more than once");
    quiet_load_a: assert property (!strap_done_out |-> pin_oe_out == 7'h00)
        else $error("pin driven during strap load");
    ack_once_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out && strap_done_out |=> wb_ack_out ##1 !wb_ack_out)
        else $error("bus answer late or long");
endmodule
bind scpa_strap_top scpa_strap_top_props i_props (.clock_in(clock_in), .rst_in(rst_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out), .mgmt_addr_straps_in(mgmt_addr_straps_in),
    .mgmt_addr_out(mgmt_addr_out), .broadcast_addr_strap_in(broadcast_addr_strap_in),
    .led_style_strap_in(led_style_strap_in), .frame_addr_in(frame_addr_in),
    .frame_addr_valid_in(frame_addr_valid_in), .frame_addr_match_out(frame_addr_match_out),
    .broadcast_addr_enable_out(broadcast_addr_enable_out), .led_style_out(led_style_out),
    .strap_done_out(strap_done_out), .pin_oe_out(pin_oe_out));

// ==== tb/tb_top.sv ====
// Testbench: bus reads and writes, frame checks and pin checks in sequence.
// Assumes LED strap pulls come from the board model; broadcast and jack straps change on the edge that asserts the second reset.
`timescale 1ns/100ps
module tb_top;
    import scpa_pkg::*;
    logic clock_in = 0, rst_in = 1, cyc = 0, stb = 0, we = 0, fv = 0, irq = 0, wake = 0;
    logic [7:0] adr = 0;
    logic [31:0] dat = 0, rd, q;
    logic [4:0] fa = 0, lit = 0;
    logic [6:0] pin_in, pin_out, pin_oe_out;
    logic match, unused_en, unused_style, unused_done;
    logic bst = 0, jck = 1, rin = 1, ral = 0;
    logic [3:0] sel = 4'h3;
    wire ack;
    logic [2:0] unused_addr;
    int fail_count = 0, check_count = 0;
    always #4 clock_in = ~clock_in;
    scpa_board_model i_scpa_board_model (.pin_out(pin_out), .pin_oe(pin_oe_out), .pull_in(7'h76), .pin_in(pin_in));
    scpa_strap_top i_scpa_strap_top (.clock_in(clock_in), .rst_in(rst_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat), .wb_dat_out(rd), .wb_ack_out(ack),
        .mgmt_addr_straps_in(3'h5), .broadcast_addr_strap_in(bst), .refclk_out_enable_strap_in(1'b1),
        .led_style_strap_in(1'b1), .jack_center_tap_compat_strap_in(jck), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_out(pin_oe_out), .led_lit_in(lit), .int_req_in(irq), .int_refclk_in(rin), .alt_refclk_in(ral),
        .wake_event_in(wake), .frame_addr_in(fa), .frame_addr_valid_in(fv), .frame_addr_match_out(match),
        .mgmt_addr_out(unused_addr), .broadcast_addr_enable_out(unused_en), .led_style_out(unused_style),
        .strap_done_out(unused_done));
    task summarize;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (e !== g) begin
            fail_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    // Classic single cycle; ack is sampled at a rising edge and the request is released at that edge
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock_in) {cyc, stb, we, adr, dat} <= {1'b1, 1'b1, w, a, d};
        do begin
            @(posedge clock_in) n++;
        end while (ack !== 1'b1 && n < 40);
        if (n >= 40) begin
            fail_count++;
            summarize;
        end
        q = rd;
        {cyc, stb, we} <= 3'h0;
    endtask
    task frame(input logic [4:0] a, input logic e);
        @(posedge clock_in) {fa, fv} <= {a, 1'b1};
        @(posedge clock_in) fv <= 1'b0;
        @(negedge clock_in) chk("match", {31'h0, e}, {31'h0, match});
    endtask
    initial begin
        repeat (20000) @(posedge clock_in);
        fail_count++;
        summarize;
    end
    initial begin
        repeat (12) @(posedge clock_in);
        rst_in <= 1'b0;
        wb(0, OFS_STRAP_STAT, 0); chk("status", 32'h0000_0e95, q);
        wb(0, OFS_CTRL, 0); chk("ctrl", 32'h0000_0001, q);
        wb(0, 8'h3c, 0); chk("unmapped", 32'h0, q);
        for (int i = 0; i < 12; i++) begin
            wb(0, OFS_VB_BASE + 8'(4 * i), 0); chk("bank", 32'h8113 + i, q);
        end
        $display("straps done");
        frame(5'h05, 1); frame(5'h00, 1); frame(5'h03, 0);
        wb(1, OFS_CTRL, 0); frame(5'h00, 0); frame(5'h05, 1);
        $display("frames done");
        @(posedge clock_in) {lit, irq} <= {5'h1f, 1'b1};
        repeat (3) @(negedge clock_in);
        chk("pins", 32'h49, 32'(pin_out)); chk("oe", 32'h7f, 32'(pin_oe_out));
        wb(1, OFS_CTRL, 32'h2);
        repeat (3) @(negedge clock_in);
        chk("clksrc", 32'h09, 32'(pin_out));
        wb(1, OFS_GPIO_DIR, 32'h7f); wb(1, OFS_GPIO_OUT, 32'h55); wb(1, OFS_GPIO_EN, 32'h7f);
        repeat (3) @(negedge clock_in);
        chk("gpio", 32'h55, 32'(pin_out)); chk("gpio oe", 32'h7f, 32'(pin_oe_out));
        wb(1, OFS_ROUTE_A, 32'h1); @(posedge clock_in) wake <= 1'b1;
        repeat (3) @(negedge clock_in);
        chk("wake", 32'h54, 32'(pin_out));
        $display("pins done");
        @(posedge clock_in) {rst_in, bst, jck} <= 3'b110;
        repeat (2) @(posedge clock_in);
        rst_in <= 1'b0;
        wb(0, OFS_STRAP_STAT, 0); chk("status2", 32'h0000_1695, q);
        wb(0, OFS_CTRL, 0); chk("ctrl2", 32'h0, q);
        wb(0, OFS_VB_BASE, 0); chk("bank2", 32'h0113, q);
        sel <= 4'h1;
        wb(1, OFS_VB_BASE, 32'haaaa); wb(0, OFS_VB_BASE, 0); chk("bank lane", 32'h01aa, q);
        $display("reset done");
        summarize;
    end
endmodule
